// *** src/iwr_pkg.sv ***
`default_nettype none
// ------------------------------------------------------------
// shared constants for the wiper register link
// ------------------------------------------------------------
package iwr_pkg;
   // arbitrary neutral type identifier, not taken from any part
   localparam logic [6:0] TYPE_ID_DEFAULT = 7'h2a;
   localparam logic [6:0] WIPER_RESET = 7'h40; // midscale
   localparam logic [7:0] REG_ADDR_WIPER = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [127:0] TAP_ONE = 128'h1;
   localparam logic [127:0] TAP_RESET = TAP_ONE << WIPER_RESET;

   // serial clock made by the controller: 400 kHz in quarters
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SYS_CLK_MHZ = 100;
   localparam int QUARTER_CYC = SCL_PERIOD_NS * SYS_CLK_MHZ / 4000;
   localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);

   // ahb-lite side of the controller
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_TXDATA = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_READ_BIT = 1;
   localparam int CMD_ID_LSB = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int STAT_RDATA_LSB = 8;

   // target states, gray along the usual path
   typedef enum logic [3:0] {
      DS_IDLE = 4'h0,
      DS_ADDR = 4'h1,
      DS_ADDR_ACK = 4'h3,
      DS_REG = 4'h2,
      DS_REG_ACK = 4'h6,
      DS_DATA = 4'h7,
      DS_DATA_ACK = 4'h5,
      DS_TX = 4'h4,
      DS_TX_ACK = 4'hc,
      DS_WAIT_STOP = 4'hd
   } iwr_dev_state_t;

   // controller states
   typedef enum logic [1:0] {
      HS_IDLE = 2'h0,
      HS_COND = 2'h1,
      HS_BYTE = 2'h3,
      HS_STOP = 2'h2
   } iwr_host_state_t;
endpackage
`default_nettype wire

// *** src/iwr_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// two-wire link: clock from the controller, open-drain data
// ------------------------------------------------------------
interface iwr_link_if;
   logic scl; // driven by the controller only
   logic host_sda_o; // data value, always low when enabled
   logic host_sda_oe_b; // low while the controller pulls data
   logic dev_sda_o;
   logic dev_sda_oe_b;
   logic sda; // resolved wired-and level with pull-up
   assign sda = ((!host_sda_oe_b && !host_sda_o) ||
                 (!dev_sda_oe_b && !dev_sda_o)) ? 1'b0 : 1'b1;
   modport dev (input scl, input sda, output dev_sda_o,
                output dev_sda_oe_b);
   modport host (output scl, output host_sda_o,
                 output host_sda_oe_b, input sda);
endinterface
`default_nettype wire

// *** src/iwr_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// two-flop synchroniser plus one history flop for edges
// ------------------------------------------------------------
module iwr_pin_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] pin,
   output var logic [W-1:0] pin_s,
   output var logic [W-1:0] pin_p
);
   logic [W-1:0] meta_q; // read only by the second stage

   // idle bus level is high, so reset to ones
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         meta_q <= '1;
         pin_s <= '1;
         pin_p <= '1;
      end else begin
         meta_q <= pin;
         pin_s <= meta_q;
         pin_p <= pin_s;
      end
   end
endmodule
`default_nettype wire

// *** src/iwr_dev_end.sv ***
// What this block does
// - data falling while clock high means start
// - data rising while clock high means stop
// - data change with clock high is start/stop
// - ignore the bus until a start
// - controller alone makes the clock
// - receiver pulls data low on ninth clock
// - acknowledge address only on own identifier
// - acknowledge every byte once write selected
// - send eight bits, release, sample acknowledge
// - no acknowledge: release and wait for stop
// - all seven upper address bits must match
// - lowest address bit: one read, zero write
// - seven-bit wiper picks one of 128 taps
// - wiper loads 40h at reset
// - top data bit dropped, read back zero
// - write is address, 00h, data, stop
// - third write byte loads the wiper
// - read uses repeated start then read address
// - controller ends read with no-ack, stop
// - every operation ends with a stop
// - new transfer only when bus idle
`timescale 1ns/100ps
`default_nettype none
module iwr_dev_end #(
   parameter logic [6:0] TYPE_ID = iwr_pkg::TYPE_ID_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   iwr_link_if.dev link,
   output var logic [6:0] wiper_position,
   output var logic [127:0] tap_select,
   output var logic wiper_load
);
   import iwr_pkg::*;

   // ------------------------------------------------------------
   // line sampling
   // ------------------------------------------------------------
   logic [1:0] pins_s; // {clock, data} after two flops
   logic [1:0] pins_p; // same, one cycle older
   logic scl_s;
   logic sda_s;
   logic scl_p;
   logic sda_p;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // the clock is only ever an input here, never driven
   iwr_pin_sync #(.W(2)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin({link.scl, link.sda}),
      .pin_s(pins_s),
      .pin_p(pins_p)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];
   assign scl_p = pins_p[1];
   assign sda_p = pins_p[0];
   assign scl_rise = scl_s && !scl_p;
   assign scl_fall = !scl_s && scl_p;
   // both lines pass the same flops, so their skew is kept;
   // a data edge seen while the clock stays high is a condition
   assign start_seen = scl_s && scl_p && sda_p && !sda_s;
   assign stop_seen = scl_s && scl_p && !sda_p && sda_s;

   // ------------------------------------------------------------
   // protocol state
   // ------------------------------------------------------------
   iwr_dev_state_t state_q; // protocol position
   logic [3:0] cnt_q; // bits moved in the current byte
   logic [7:0] rx_q; // incoming byte, msb first
   logic [7:0] tx_q; // outgoing byte, msb first
   logic rw_q; // direction from the address byte
   logic reg_ok_q; // register byte addressed the wiper
   logic ack_q; // controller acknowledged last sent byte
   logic sda_oe_b_q; // low while this end pulls data low
   logic sda_o_q; // value on the pin, held low
   logic [6:0] wiper_q;
   logic [7:0] rx_word; // byte including the bit now sampled
   logic [7:0] rd_word; // byte returned on a read
   logic load_w;

   assign rx_word = {rx_q[6:0], sda_s};
   assign rd_word = {1'b0, wiper_q};
   // wiper loads at the last data bit of a write to 00h
   assign load_w = (state_q == DS_DATA) && scl_rise && reg_ok_q &&
                   (cnt_q == BITS_PER_BYTE - 4'h1) &&
                   !start_seen && !stop_seen;

   // main sequencer on the system clock, stepped by edges of the sampled bus clock;
   // start and stop outrank anything a bit edge would do
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q <= DS_IDLE;
         cnt_q <= 4'h0;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         rw_q <= 1'b0;
         reg_ok_q <= 1'b0;
         ack_q <= 1'b0;
         sda_oe_b_q <= 1'b1;
      end else if (start_seen) begin
         // plain or repeated start restarts the address phase
         state_q <= DS_ADDR;
         cnt_q <= 4'h0;
         sda_oe_b_q <= 1'b1;
      end else if (stop_seen) begin
         state_q <= DS_IDLE;
         sda_oe_b_q <= 1'b1;
      end else begin
         case (state_q)
            DS_IDLE: begin
               // deaf to everything but a start
               sda_oe_b_q <= 1'b1;
            end
            DS_ADDR, DS_REG, DS_DATA: begin
               // shift in on rising clock
               if (scl_rise && cnt_q != BITS_PER_BYTE) begin
                  rx_q <= rx_word;
                  cnt_q <= cnt_q + 4'h1;
               end
               // after the eighth bit, answer on the falling clock
               if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  cnt_q <= 4'h0;
                  if (state_q == DS_ADDR) begin
                     if (rx_q[7:1] == TYPE_ID) begin
                        sda_oe_b_q <= 1'b0;
                        rw_q <= rx_q[0];
                        state_q <= DS_ADDR_ACK;
                     end else begin
                        // not ours: stay silent until the stop
                        state_q <= DS_WAIT_STOP;
                     end
                  end else if (state_q == DS_REG) begin
                     reg_ok_q <= (rx_q == REG_ADDR_WIPER);
                     sda_oe_b_q <= 1'b0;
                     state_q <= DS_REG_ACK;
                  end else begin
                     sda_oe_b_q <= 1'b0;
                     state_q <= DS_DATA_ACK;
                  end
               end
            end
            DS_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw_q) begin
                     // put the first read bit out right away
                     sda_oe_b_q <= rd_word[7];
                     tx_q <= {rd_word[6:0], 1'b0};
                     cnt_q <= 4'h1;
                     state_q <= DS_TX;
                  end else begin
                     sda_oe_b_q <= 1'b1;
                     state_q <= DS_REG;
                  end
               end
            end
            DS_REG_ACK, DS_DATA_ACK: begin
               // any later byte is taken as more data and acked
               if (scl_fall) begin
                  sda_oe_b_q <= 1'b1;
                  state_q <= DS_DATA;
               end
            end
            DS_TX: begin
               if (scl_fall) begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     // hand the line over for the ninth bit
                     sda_oe_b_q <= 1'b1;
                     state_q <= DS_TX_ACK;
                  end else begin
                     // ones are sent by letting go, never driven
                     sda_oe_b_q <= tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            DS_TX_ACK: begin
               if (scl_rise) begin
                  ack_q <= !sda_s;
               end
               if (scl_fall) begin
                  if (ack_q) begin
                     // acked: keep sending the same register
                     sda_oe_b_q <= rd_word[7];
                     tx_q <= {rd_word[6:0], 1'b0};
                     cnt_q <= 4'h1;
                     state_q <= DS_TX;
                  end else begin
                     state_q <= DS_WAIT_STOP;
                  end
               end
            end
            DS_WAIT_STOP: begin
               sda_oe_b_q <= 1'b1;
            end
            default: begin
               state_q <= DS_IDLE;
               sda_oe_b_q <= 1'b1;
            end
         endcase
      end
   end

   // the pin value is a constant low, so the line is never
   // driven high and other open-drain agents can share it
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sda_o_q <= 1'b0;
      end else begin
         sda_o_q <= 1'b0;
      end
   end

   assign link.dev_sda_o = sda_o_q;
   assign link.dev_sda_oe_b = sda_oe_b_q;

   // ------------------------------------------------------------
   // wiper register and tap decode
   // ------------------------------------------------------------
   // volatile: every reset gives it midscale, a write gives it the low seven bits of the data byte
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wiper_q <= WIPER_RESET;
         tap_select <= TAP_RESET;
         wiper_load <= 1'b0;
      end else begin
         wiper_load <= load_w;
         if (load_w) begin
            // msb of the data byte is dropped
            wiper_q <= rx_word[6:0];
            tap_select <= TAP_ONE << rx_word[6:0];
         end
      end
   end

   // wiper_q already sits in a flop, so it feeds the port
   assign wiper_position = wiper_q;
endmodule
`default_nettype wire

// *** src/iwr_host_end.sv ***
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module iwr_host_end (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output var logic [31:0] hrdata,
   output var logic hreadyout,
   output var logic hresp,
   iwr_link_if.host link
);
   import iwr_pkg::*;

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   iwr_host_state_t state_q;
   logic wr_pend_q; // write data phase pending
   logic [7:0] addr_q; // latched word offset
   logic [7:0] txdata_q; // data byte for the next write
   logic [7:0] rdata_q; // byte returned by the last read
   logic nack_q; // an address or data byte was not acked
   logic read_q; // current operation is a read
   logic [6:0] id_q; // target identifier
   logic [31:0] status; // status word
   logic cmd_go;

   assign status = (32'(rdata_q) << STAT_RDATA_LSB) |
                   (32'(nack_q) << STAT_NACK_BIT) |
                   (32'(state_q != HS_IDLE) << STAT_BUSY_BIT);
   // a go written while busy is dropped
   assign cmd_go = wr_pend_q && addr_q == OFS_CMD &&
                   hwdata[CMD_GO_BIT] && state_q == HS_IDLE;

   // zero-wait slave: read data made in the address phase;
   // hsize is not checked since only words are carried
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         if (hready && hsel && htrans == HTRANS_NONSEQ) begin
            wr_pend_q <= hwrite;
            addr_q <= haddr[7:0];
            // unmapped or write-only offsets read as zero
            if (!hwrite && haddr[7:0] == OFS_STATUS) begin
               hrdata <= status;
            end else if (!hwrite && haddr[7:0] == OFS_TXDATA) begin
               hrdata <= 32'(txdata_q);
            end else begin
               hrdata <= 32'h0000_0000;
            end
         end
      end
   end

   // data byte register
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         txdata_q <= 8'h00;
      end else if (wr_pend_q && addr_q == OFS_TXDATA) begin
         txdata_q <= hwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // link sequencer, four quarter ticks per bus clock
   // ------------------------------------------------------------
   logic [7:0] qcnt_q;
   logic tick;
   logic [1:0] ph_q; // quarter within bit or condition
   logic [3:0] bit_q; // 0..7 data, 8 acknowledge
   logic [1:0] step_q; // byte index within the operation
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic scl_q;
   logic sda_oe_b_q;
   logic sda_o_q;
   logic sda_s; // returned data after two flops
   logic rx_byte; // current byte is read from the target
   logic last_byte;

   iwr_pin_sync #(.W(1)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin(link.sda),
      .pin_s(sda_s),
      .pin_p()
   );

   assign tick = qcnt_q == QUARTER_LAST;
   assign rx_byte = read_q && step_q == 2'h3;
   assign last_byte = read_q ? step_q == 2'h3 : step_q == 2'h2;

   // byte sent at each step of the operation
   function automatic logic [7:0] byte_at(input logic [1:0] s);
      logic [7:0] b;
      b = {id_q, 1'b0};
      if (s == 2'h1) begin
         b = REG_ADDR_WIPER;
      end else if (s == 2'h2) begin
         b = read_q ? {id_q, 1'b1} : txdata_q;
      end else if (s == 2'h3) begin
         b = 8'hff; // released while the target sends
      end
      return b;
   endfunction

   // quarter tick divider, held still while idle
   always_ff @(posedge sys_clk) begin
      if (!rst_b || state_q == HS_IDLE || tick) begin
         qcnt_q <= 8'h00;
      end else begin
         qcnt_q <= qcnt_q + 8'h01;
      end
   end

   // operation sequencer; data bits change only with the clock low
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q <= HS_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         step_q <= 2'h0;
         tx_q <= 8'hff;
         rx_q <= 8'h00;
         rdata_q <= 8'h00;
         nack_q <= 1'b0;
         read_q <= 1'b0;
         id_q <= 7'h00;
         scl_q <= 1'b1;
         sda_oe_b_q <= 1'b1;
         sda_o_q <= 1'b0;
      end else if (cmd_go) begin
         // only from idle, after the previous stop
         state_q <= HS_COND;
         read_q <= hwdata[CMD_READ_BIT];
         id_q <= hwdata[CMD_ID_LSB +: 7];
         nack_q <= 1'b0;
         step_q <= 2'h0;
         ph_q <= 2'h0;
      end else if (tick) begin
         ph_q <= ph_q + 2'h1;
         case (state_q)
            HS_COND: begin
               // start: data falls while the clock is high
               if (ph_q == 2'h0) sda_oe_b_q <= 1'b1;
               if (ph_q == 2'h1) scl_q <= 1'b1;
               if (ph_q == 2'h2) sda_oe_b_q <= 1'b0;
               if (ph_q == 2'h3) begin
                  scl_q <= 1'b0;
                  tx_q <= byte_at(step_q);
                  bit_q <= 4'h0;
                  state_q <= HS_BYTE;
               end
            end
            HS_BYTE: begin
               if (ph_q == 2'h0) begin
                  // ninth bit released: ack by target, nack on read
                  sda_oe_b_q <= (bit_q == BITS_PER_BYTE) ? 1'b1 :
                                tx_q[7];
               end
               if (ph_q == 2'h1) scl_q <= 1'b1;
               if (ph_q == 2'h2) begin
                  if (bit_q != BITS_PER_BYTE) begin
                     rx_q <= {rx_q[6:0], sda_s};
                  end else if (!rx_byte && sda_s) begin
                     nack_q <= 1'b1;
                  end
               end
               if (ph_q == 2'h3) begin
                  scl_q <= 1'b0;
                  tx_q <= {tx_q[6:0], 1'b1};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == BITS_PER_BYTE) begin
                     bit_q <= 4'h0;
                     if (rx_byte) rdata_q <= rx_q;
                     if (nack_q || last_byte) begin
                        state_q <= HS_STOP;
                     end else if (read_q && step_q == 2'h1) begin
                        step_q <= 2'h2;
                        state_q <= HS_COND;
                     end else begin
                        step_q <= step_q + 2'h1;
                        tx_q <= byte_at(step_q + 2'h1);
                     end
                  end
               end
            end
            HS_STOP: begin
               // stop: data rises while the clock is high
               if (ph_q == 2'h0) sda_oe_b_q <= 1'b0;
               if (ph_q == 2'h1) scl_q <= 1'b1;
               if (ph_q == 2'h2) sda_oe_b_q <= 1'b1;
               if (ph_q == 2'h3) state_q <= HS_IDLE;
            end
            default: begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end

   assign link.scl = scl_q;
   assign link.host_sda_o = sda_o_q;
   assign link.host_sda_oe_b = sda_oe_b_q;
endmodule
`default_nettype wire

// *** tb/iwr_link_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// link checks, sampled on the system clock
// ----------------------------------------
module iwr_link_asserts (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_o,
   input wire logic host_sda_oe_b,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe_b
);
   logic scl_p_q, sda_p_q; // previous line levels
   logic frame_q, first_q, rd_q; // inside a frame, first byte, read
   logic [3:0] bit_q; // clock rises in this byte, ninth wraps
   logic [7:0] low_q; // cycles since the clock went low, saturating
   logic start, stop;
   assign start = scl && scl_p_q && sda_p_q && !sda;
   assign stop = scl && scl_p_q && !sda_p_q && sda;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // line history; low time restarts whenever the clock is high
   always_ff @(posedge sys_clk) begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      low_q <= scl ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
   end
   // frame lasts from any start to the next stop
   always_ff @(posedge sys_clk) begin
      if (!rst_b || stop) frame_q <= 1'b0;
      else if (start) frame_q <= 1'b1;
   end
   // bit position; a repeated start restarts the address byte
   always_ff @(posedge sys_clk) begin
      if (!rst_b || start) begin
         bit_q <= 4'h0;
         first_q <= 1'b1;
         rd_q <= 1'b0;
      end else if (scl && !scl_p_q) begin
         bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
         first_q <= first_q && bit_q != 4'h8;
         if (first_q && bit_q == 4'h7) rd_q <= sda;
      end
   end
   a_dev_low: assert property (!dev_sda_oe_b |-> !dev_sda_o)
      else $error("device drives data high");
   a_host_low: assert property (!host_sda_oe_b |-> !host_sda_o)
      else $error("controller drives data high");
   a_quiet_idle: assert property (!dev_sda_oe_b |-> frame_q)
      else $error("device drives outside a frame");
   a_turn_low: assert property ($changed(dev_sda_oe_b) |->
      !scl && low_q <= 8'h06) else $error("device data change late");
   a_ack_ninth: assert property ($fell(dev_sda_oe_b) |->
      bit_q == 4'h8 || rd_q) else $error("acknowledge out of place");
   a_stop_frees: assert property (stop |-> dev_sda_oe_b [*8])
      else $error("device holds data after stop");
   a_clock_high: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   a_idle_clock: assert property (!frame_q && !start |-> scl)
      else $error("clock low on idle bus");
endmodule
`default_nettype wire

// *** tb/i2c_wiper_register_slave_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); \
   end \
end
// ----------------------------------------
// both ends joined, driven over the bus
// ----------------------------------------
module i2c_wiper_register_slave_bench;
   import iwr_pkg::*;
   logic sys_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, wiper_load;
   logic [31:0] haddr, hwdata, hrdata, st;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] wiper_position;
   logic [127:0] tap_select;
   int fail_count, check_count, cyc, loads;
   iwr_link_if i_iwr_link_if ();
   iwr_host_end i_iwr_host_end (.sys_clk(sys_clk), .rst_b(rst_b),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link(i_iwr_link_if));
   iwr_dev_end i_iwr_dev_end (.sys_clk(sys_clk), .rst_b(rst_b),
      .link(i_iwr_link_if), .wiper_position(wiper_position),
      .tap_select(tap_select), .wiper_load(wiper_load));
   iwr_link_asserts i_iwr_link_asserts (.sys_clk(sys_clk), .rst_b(rst_b),
      .scl(i_iwr_link_if.scl), .sda(i_iwr_link_if.sda),
      .host_sda_o(i_iwr_link_if.host_sda_o),
      .host_sda_oe_b(i_iwr_link_if.host_sda_oe_b),
      .dev_sda_o(i_iwr_link_if.dev_sda_o),
      .dev_sda_oe_b(i_iwr_link_if.dev_sda_oe_b));
   assign hready = hreadyout; // single slave owns the bus
   // 100 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // load pulses and a hang limit well above the ~50k needed
   always @(posedge sys_clk) begin
      cyc++;
      loads += int'(wiper_load === 1'b1);
      if (cyc == 80000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic do_reset;
      rst_b <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
   endtask
   // one single word transfer; caller stands just after an edge
   task automatic ahb(input logic wr, input logic [7:0] ofs,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h000000, ofs};
      hwrite <= wr;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // launch one link operation and poll until it is over
   task automatic xfer(input logic [6:0] id, input logic rd,
                       input logic [7:0] d);
      int n;
      ahb(1'b1, OFS_TXDATA, {24'h000000, d}, st);
      ahb(1'b1, OFS_CMD, {17'h00000, id, 6'h00, rd, 1'b1}, st);
      n = 0;
      // busy may rise a cycle late, so see it set before waiting
      do begin
         ahb(1'b0, OFS_STATUS, 32'h0, st);
         n++;
      end while (st[STAT_BUSY_BIT] !== 1'b1 && n < 8);
      // a dropped go would otherwise pass as an early finish
      `CHK(st[STAT_BUSY_BIT], 1'b1)
      do begin
         ahb(1'b0, OFS_STATUS, 32'h0, st);
         n++;
      end while (st[STAT_BUSY_BIT] !== 1'b0 && n < 20000);
      `CHK(st[STAT_BUSY_BIT], 1'b0)
   endtask
   task automatic t_reset_values;
      ahb(1'b0, 8'h0c, 32'h0, st);
      `CHK(st, 32'h0)
      // controller idle, no nack and no read byte after reset
      ahb(1'b0, OFS_STATUS, 32'h0, st);
      `CHK(st, 32'h0)
      `CHK(wiper_position, WIPER_RESET)
      `CHK(tap_select, TAP_RESET)
   endtask
   // top data bit must be dropped, one load per data byte
   task automatic t_write(input logic [7:0] d);
      int n0;
      n0 = loads;
      xfer(TYPE_ID_DEFAULT, 1'b0, d);
      `CHK(st[STAT_NACK_BIT], 1'b0)
      `CHK(wiper_position, d[6:0])
      `CHK(tap_select, TAP_ONE << d[6:0])
      `CHK(loads, n0 + 1)
   endtask
   task automatic t_read(input logic [6:0] exp);
      xfer(TYPE_ID_DEFAULT, 1'b1, 8'h00);
      `CHK(st[STAT_NACK_BIT], 1'b0)
      `CHK(st[15:8], {1'b0, exp})
   endtask
   // identifiers off in the lowest and the highest bit
   task automatic t_wrong_id;
      logic [6:0] w;
      w = wiper_position;
      xfer(7'h2b, 1'b0, 8'h11);
      `CHK(st[STAT_NACK_BIT], 1'b1)
      xfer(7'h6a, 1'b0, 8'h11);
      `CHK(st[STAT_NACK_BIT], 1'b1)
      `CHK(wiper_position, w)
   endtask
   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      @(posedge sys_clk);
      do_reset();
      t_reset_values();
      t_read(WIPER_RESET);
      t_write(8'hd5);
      t_write(8'h80);
      t_write(8'h7f);
      t_read(7'h7f);
      t_wrong_id();
      // reset in mid-run must bring midscale back
      do_reset();
      t_reset_values();
      end_sim();
   end
endmodule
`default_nettype wire
